// >>> core/swrc_pkg.sv
package swrc_pkg;

   // ==================================================================
   // Timing: one microsecond tick from the 20 MHz clock
   localparam int         CLK_HZ       = 20_000_000;
   localparam logic [4:0] DIV_LAST     = 5'(CLK_HZ / 1_000_000 - 1);
   localparam logic [8:0] RESET_US     = 9'd480; // Low time meaning reset
   localparam logic [8:0] PRES_WAIT_US = 9'd30;  // Within 15..60 us
   localparam logic [8:0] PRES_LOW_US  = 9'd120; // Within 60..240 us
   localparam logic [5:0] SLOT_US      = 6'd30;  // Sample and hold point

   // ==================================================================
   // Selection commands and bit counts
   localparam logic [7:0] CMD_SEARCH = 8'hf0;
   localparam logic [7:0] CMD_READ   = 8'h33;
   localparam logic [7:0] CMD_MATCH  = 8'h55;
   localparam logic [7:0] CMD_BCAST  = 8'hcc;
   localparam logic [7:0] CMD_ALARM  = 8'hec;
   localparam logic [5:0] BYTE_LAST  = 6'd7;
   localparam logic [5:0] CODE_LAST  = 6'd63;
   localparam int         CRC_BITS   = 56;
   localparam logic [7:0] CRC_POLY   = 8'h8c; // Reflected x^8+x^5+x^4+1

   // Family code value is arbitrary
   localparam logic [7:0]  FAMILY_CODE  = 8'h5a;
   localparam logic [47:0] SERIAL_RESET = 48'h0000_0000_0001;

   // ==================================================================
   // States and carriers
   typedef enum logic [3:0] {
      ST_IDLE       = 4'b0000,
      ST_WAIT_RISE  = 4'b0001,
      ST_PRES_WAIT  = 4'b0010,
      ST_PRES_DRIVE = 4'b0011,
      ST_ROM_CMD    = 4'b0100,
      ST_READ_TX    = 4'b0101,
      ST_MATCH      = 4'b0110,
      ST_SEARCH     = 4'b0111,
      ST_FUNC       = 4'b1000
   } swrc_state_t;

   typedef struct packed {
      logic       sel;
      logic       bcast;
      logic [7:0] cmd;
   } swrc_func_t;

   // Serial check byte over the first n bits, LSB first
   function automatic logic [7:0] swrc_crc8(input logic [63:0] d,
                                            input int n);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (i < n) begin
            fb = c[0] ^ d[i];
            c = {1'b0, c[7:1]} ^ (fb ? CRC_POLY : 8'h00);
         end
      end
      return c;
   endfunction

endpackage

// >>> core/swrc_top.sv
// Notes on behaviour
// - Both check bytes use the polynomial x^8 + x^5 + x^4 + 1.
// - Code check byte covers the first 56 code bits, held in top byte.
// - Scratchpad check byte covers bytes 0..7, recomputed on every change.
// - Generator starts at zero and absorbs one bit at a time, LSB first.
// - No check-value comparison ever stops a command sequence here.
// - Commands and data travel least significant bit first, both ways.
// - The line is only pulled low or released, never driven high.
// - Any length of high time between bits keeps the state intact.
// - Line low for more than 480 us is a bus reset, abandoning all.
// - Access order is reset, selection, function; other orders ignored.
// - Each transaction starts with master reset then slave presence.
// - Decode one of five selection commands; functions only after one.
// - Search: send bit and complement, drop out on master mismatch.
// - Code readout sends the whole 64-bit code.
// - Address select compares 64 bits; mismatch stays silent to reset.
// - Broadcast select marks the device selected without any code.
// - Alarm search acts as search only while the alarm flag is set.
// - Alarm flag is refreshed after each conversion from trip values.
// - Code is family byte low, 48-bit serial, check byte high.
// - After the rise wait 15..60 us, then pull low 60..240 us.
module swrc_top
   import swrc_pkg::*;
#(
   parameter logic [47:0] SERIAL = SERIAL_RESET
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Open-drain data line
   input  wire logic        dq_in,
   output      logic        dq_out,
   output      logic        dq_oe,
   // Scratchpad contents and conversion result
   input  wire logic [63:0] scratch,
   input  wire logic        conv_done,
   input  wire logic [15:0] temp_reading,
   input  wire logic [7:0]  upper_trip_value,
   input  wire logic [7:0]  lower_trip_value,
   // Function command handoff
   output      swrc_func_t  func,
   output      logic        func_valid,
   output      logic        bus_reset,
   output      logic        alarm,
   output      logic [7:0]  scratch_crc
);
   import swrc_pkg::*;

   // Identification code with its own check byte on top
   localparam logic [55:0] CODE_LOW = {SERIAL, FAMILY_CODE};
   localparam logic [63:0] ROM_CODE =
      {swrc_crc8({8'h00, CODE_LOW}, CRC_BITS), CODE_LOW};

   swrc_state_t state_q;
   swrc_func_t  func_q;
   logic [4:0]  div_q;
   logic        line_q;
   logic [8:0]  low_us_q;
   logic [8:0]  pres_us_q;
   logic        slot_q;
   logic [5:0]  slot_us_q;
   logic [7:0]  sh_q;
   logic [5:0]  bit_cnt_q;
   logic [1:0]  ph_q;
   logic        match_ok_q;
   logic        alarm_q;
   logic        dq_oe_q;
   logic        dq_out_q;
   logic        func_valid_q;
   logic        bus_reset_q;
   logic [7:0]  scratch_crc_q;

   logic        tick, fall, rise, rst_evt, slot_on, bit_done, rx;
   logic        code_bit, tx_en, tx_bit, pres_end, wait_end;
   logic        got_cmd, sel_evt, bcast_evt, func_evt;
   logic [7:0]  cmd_next;

   // ==================================================================
   // Microsecond divider and line edges
   assign tick = (div_q == DIV_LAST);
   assign fall = line_q & ~dq_in;
   assign rise = ~line_q & dq_in;

   // Free-running divider; slot timing only needs about one us accuracy
   always_ff @(posedge clock) begin
      if (srst || tick) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end

   // Previous line level; idle line is high
   always_ff @(posedge clock) begin
      if (srst) begin
         line_q <= 1'b1;
      end else begin
         line_q <= dq_in;
      end
   end

   // ==================================================================
   // Reset detection: low time counted in us, saturating
   assign rst_evt = ~dq_in & tick & (low_us_q == RESET_US - 9'h001);

   always_ff @(posedge clock) begin
      if (srst || dq_in) begin
         low_us_q <= 9'h000; // High time of any length is harmless
      end else if (tick && low_us_q != RESET_US) begin
         low_us_q <= low_us_q + 9'h001;
      end
   end

   // ==================================================================
   // Bit slots: opened by the master's falling edge, closed at 30 us
   assign slot_on  = (state_q == ST_ROM_CMD) || (state_q == ST_READ_TX) ||
                     (state_q == ST_MATCH) || (state_q == ST_SEARCH) ||
                     (state_q == ST_FUNC);
   assign bit_done = slot_q & tick & (slot_us_q == SLOT_US - 6'h01);
   assign rx       = dq_in;

   always_ff @(posedge clock) begin
      if (srst || rst_evt) begin
         slot_q    <= 1'b0;
         slot_us_q <= 6'h00;
      end else if (fall && slot_on && !slot_q) begin
         slot_q    <= 1'b1;
         slot_us_q <= 6'h00;
      end else if (slot_q && tick) begin
         slot_q    <= ~bit_done;
         slot_us_q <= slot_us_q + 6'h01;
      end
   end

   // ==================================================================
   // Transmit bit selection
   assign code_bit = ROM_CODE[bit_cnt_q]; // Family LSB first
   assign tx_en    = (state_q == ST_READ_TX) ||
                     (state_q == ST_SEARCH && ph_q != 2'h2);
   assign tx_bit   = (state_q == ST_SEARCH && ph_q == 2'h1) ?
                     ~code_bit : code_bit;

   // Received byte, shifted in LSB first
   assign cmd_next = {rx, sh_q[7:1]};
   assign got_cmd  = bit_done && state_q == ST_ROM_CMD &&
                     bit_cnt_q == BYTE_LAST;
   assign bcast_evt = got_cmd && cmd_next == CMD_BCAST;
   assign sel_evt  = bit_done && bit_cnt_q == CODE_LAST &&
                     (state_q == ST_READ_TX ||
                      (state_q == ST_MATCH && match_ok_q &&
                       rx == code_bit));
   assign func_evt = bit_done && state_q == ST_FUNC &&
                     bit_cnt_q == BYTE_LAST;

   // Presence timing points
   assign wait_end = state_q == ST_PRES_WAIT && tick &&
                     pres_us_q == PRES_WAIT_US - 9'h001;
   assign pres_end = state_q == ST_PRES_DRIVE && tick &&
                     pres_us_q == PRES_LOW_US - 9'h001;

   // ==================================================================
   // Transaction sequence; a reset from any state wins
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q    <= ST_IDLE;
         pres_us_q  <= 9'h000;
         sh_q       <= 8'h00;
         bit_cnt_q  <= 6'h00;
         ph_q       <= 2'h0;
         match_ok_q <= 1'b0;
      end else if (rst_evt) begin
         state_q    <= ST_WAIT_RISE;
         bit_cnt_q  <= 6'h00;
         ph_q       <= 2'h0;
      end else begin
         case (state_q)
            ST_WAIT_RISE: begin
               pres_us_q <= 9'h000;
               if (rise) begin
                  state_q <= ST_PRES_WAIT;
               end
            end
            ST_PRES_WAIT: begin
               pres_us_q <= tick ? pres_us_q + 9'h001 : pres_us_q;
               if (wait_end) begin
                  state_q   <= ST_PRES_DRIVE;
                  pres_us_q <= 9'h000;
               end
            end
            ST_PRES_DRIVE: begin
               pres_us_q <= tick ? pres_us_q + 9'h001 : pres_us_q;
               if (pres_end) begin
                  state_q   <= ST_ROM_CMD;
                  bit_cnt_q <= 6'h00;
               end
            end
            ST_ROM_CMD: begin
               if (bit_done) begin
                  sh_q      <= cmd_next;
                  bit_cnt_q <= bit_cnt_q + 6'h01;
               end
               if (got_cmd) begin
                  bit_cnt_q  <= 6'h00;
                  ph_q       <= 2'h0;
                  match_ok_q <= 1'b1;
                  // Unknown commands leave the device silent
                  case (cmd_next)
                     CMD_READ:   state_q <= ST_READ_TX;
                     CMD_MATCH:  state_q <= ST_MATCH;
                     CMD_BCAST:  state_q <= ST_FUNC;
                     CMD_SEARCH: state_q <= ST_SEARCH;
                     CMD_ALARM:  state_q <= alarm_q ? ST_SEARCH
                                                    : ST_IDLE;
                     default:    state_q <= ST_IDLE;
                  endcase
               end
            end
            ST_READ_TX, ST_MATCH: begin
               if (bit_done) begin
                  bit_cnt_q <= bit_cnt_q + 6'h01;
                  if (rx != code_bit) begin
                     match_ok_q <= 1'b0;
                  end
                  if (bit_cnt_q == CODE_LAST) begin
                     bit_cnt_q <= 6'h00;
                     state_q   <= sel_evt ? ST_FUNC : ST_IDLE;
                  end
               end
            end
            ST_SEARCH: begin
               if (bit_done) begin
                  ph_q <= ph_q + 2'h1;
                  if (ph_q == 2'h2) begin
                     ph_q      <= 2'h0;
                     bit_cnt_q <= bit_cnt_q + 6'h01;
                     // Drop out on mismatch; after the last bit the
                     // master must reinitialise anyway
                     if (rx != code_bit || bit_cnt_q == CODE_LAST) begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
            end
            ST_FUNC: begin
               if (bit_done) begin
                  sh_q      <= cmd_next;
                  bit_cnt_q <= bit_cnt_q + 6'h01;
               end
               if (func_evt) begin
                  state_q <= ST_IDLE; // Function block takes over
               end
            end
            default: begin
               state_q <= state_q; // ST_IDLE waits for a bus reset
            end
         endcase
      end
   end

   // ==================================================================
   // Line driver: only ever pulls low, released otherwise
   always_ff @(posedge clock) begin
      if (srst || rst_evt) begin
         dq_oe_q <= 1'b0;
      end else if (wait_end) begin
         dq_oe_q <= 1'b1; // Presence pulse
      end else if (pres_end) begin
         dq_oe_q <= 1'b0;
      end else if (fall && slot_on && !slot_q && tx_en && !tx_bit) begin
         dq_oe_q <= 1'b1; // Send a zero
      end else if (bit_done) begin
         dq_oe_q <= 1'b0;
      end
   end

   // Output level is always low; no strong high drive exists
   always_ff @(posedge clock) begin
      dq_out_q <= 1'b0;
   end

   // ==================================================================
   // Selection state and function command handoff
   always_ff @(posedge clock) begin
      if (srst || rst_evt) begin
         func_q       <= '0;
         func_valid_q <= 1'b0;
      end else begin
         func_valid_q <= func_evt;
         if (bcast_evt) begin
            func_q.bcast <= 1'b1;
         end
         if (sel_evt) begin
            func_q.sel <= 1'b1;
         end
         if (func_evt) begin
            func_q.cmd <= cmd_next;
         end
      end
   end

   // One-cycle bus reset indication for the function logic
   always_ff @(posedge clock) begin
      if (srst) begin
         bus_reset_q <= 1'b0;
      end else begin
         bus_reset_q <= rst_evt;
      end
   end

   // ==================================================================
   // Alarm flag: reading bits 8:1 against the trip values
   always_ff @(posedge clock) begin
      if (srst) begin
         alarm_q <= 1'b0;
      end else if (conv_done) begin
         alarm_q <= ($signed(temp_reading[8:1]) >
                     $signed(upper_trip_value)) ||
                    ($signed(temp_reading[8:1]) <
                     $signed(lower_trip_value));
      end
   end

   // Scratchpad check byte follows the contents every cycle; nothing
   // here compares it, the master alone judges it
   always_ff @(posedge clock) begin
      if (srst) begin
         scratch_crc_q <= 8'h00;
      end else begin
         scratch_crc_q <= swrc_crc8(scratch, 64);
      end
   end

   assign dq_out      = dq_out_q;
   assign dq_oe       = dq_oe_q;
   assign func        = func_q;
   assign func_valid  = func_valid_q;
   assign bus_reset   = bus_reset_q;
   assign alarm       = alarm_q;
   assign scratch_crc = scratch_crc_q;

   // ==================================================================
   // Assertions
   // Presence length in clock cycles; a counter instead of a long delay
   // range keeps the property cheap to evaluate
   localparam int PRES_CYC_LAST =
      int'(PRES_LOW_US) * (int'(DIV_LAST) + 1) - 1;
   logic [11:0] pres_cyc_q;

   // Cycles since the presence pulse started
   always_ff @(posedge clock) begin
      if (srst || wait_end) begin
         pres_cyc_q <= 12'h000;
      end else if (state_q == ST_PRES_DRIVE) begin
         pres_cyc_q <= pres_cyc_q + 12'h001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_code_crc: assert property (
      swrc_crc8(ROM_CODE, 64) == 8'h00)
      else $error("code check byte wrong");
   a_scratch_crc: assert property (
      ##1 scratch_crc_q == swrc_crc8($past(scratch), 64))
      else $error("scratchpad check byte stale");
   a_reset_clear: assert property (
      rst_evt |=> state_q == ST_WAIT_RISE && !func_q.sel &&
      !func_q.bcast && bus_reset_q && !dq_oe_q)
      else $error("bus reset not taken");
   a_presence_low: assert property (
      wait_end |=> dq_oe_q)
      else $error("presence pulse not started");
   a_presence_hold: assert property (
      state_q == ST_PRES_DRIVE |-> dq_oe_q)
      else $error("presence pulse broken");
   a_presence_len: assert property (
      pres_end |-> dq_oe_q && pres_cyc_q == 12'(PRES_CYC_LAST))
      else $error("presence pulse length wrong");
   a_oe_owner: assert property (
      dq_oe_q |-> state_q == ST_PRES_DRIVE || slot_q)
      else $error("line pulled outside slot");
   a_func_after_sel: assert property (
      func_valid_q |-> func_q.sel || func_q.bcast)
      else $error("function without selection");
   a_search_drop: assert property (
      bit_done && state_q == ST_SEARCH && ph_q == 2'h2 &&
      rx != code_bit |=> state_q == ST_IDLE)
      else $error("search mismatch ignored");
   a_alarm_gate: assert property (
      got_cmd && cmd_next == CMD_ALARM && !alarm_q |=>
      state_q == ST_IDLE)
      else $error("alarm search without alarm");
   a_match_sel: assert property (
      $rose(func_q.sel) |-> $past(state_q) == ST_MATCH ||
      $past(state_q) == ST_READ_TX)
      else $error("selected without code");
   a_alarm_upd: assert property (
      conv_done |=> alarm_q == (
      ($signed($past(temp_reading[8:1])) >
       $signed($past(upper_trip_value))) ||
      ($signed($past(temp_reading[8:1])) <
       $signed($past(lower_trip_value)))))
      else $error("alarm flag not refreshed");

   c_presence: cover property (pres_end);
   c_bcast: cover property (func_valid_q && func_q.bcast);
   c_match: cover property (sel_evt && state_q == ST_MATCH);
   c_search_end: cover property (
      bit_done && state_q == ST_SEARCH && bit_cnt_q == CODE_LAST);

endmodule // swrc_top

// >>> tb/swrc_master_model.sv
module swrc_master_model (
   // Clock and device side of the line
   input  wire logic clock,
   input  wire logic dev_oe,
   input  wire logic dev_out,
   // Resolved line and sampled bits
   output      logic line,
   output      logic rd_valid,
   output      logic rd_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   import swrc_pkg::*;

   // ==================================================================
   // Line resolution
   logic m_low = 1'b0;

   // Wired-AND with a pull-up: a released line reads high
   assign line = !(m_low || (dev_oe && !dev_out));

   initial begin
      rd_valid = 1'b0;
      rd_bit   = 1'b0;
   end

   // ==================================================================
   // Slot tasks; every change lands just after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Hand one sampled level to the bench for a single cycle
   task automatic note_bit();
      rd_bit   = line;
      rd_valid = 1'b1;
      tick(1);
      rd_valid = 1'b0;
   endtask

   // Low beyond 480 us, release, then look for presence
   task automatic bus_init();
      m_low = 1'b1;
      tick(9640);
      m_low = 1'b0;
      tick(1400);
      note_bit();
      tick(1800);
   endtask

   // Short low for a one, low past the sample point for a zero
   task automatic write_bit(input logic b);
      m_low = 1'b1;
      tick(b ? 40 : 640);
      m_low = 1'b0;
      tick(b ? 620 : 20); // Released high between slots
   endtask

   // Bytes leave least significant bit first
   task automatic write_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         write_bit(b[i]);
      end
   endtask

   // Start the slot, release, sample well before the device lets go
   task automatic read_bit();
      m_low = 1'b1;
      tick(20);
      m_low = 1'b0;
      tick(280);
      note_bit();
      tick(359);
   endtask

endmodule // swrc_master_model

// >>> tb/swrc_tb_top.sv
module swrc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import swrc_pkg::*;

   // ==================================================================
   // Signals
   localparam logic [47:0] SER = 48'h3c5a_9e01_7b24;
   logic        clock            = 1'b0;
   logic        srst             = 1'b1;
   logic [63:0] scratch          = 64'h0;
   logic        conv_done        = 1'b0;
   logic [15:0] temp_reading     = 16'h0;
   logic [7:0]  upper_trip_value = 8'h14;
   logic [7:0]  lower_trip_value = 8'hf6;
   logic        line, dq_out, dq_oe, func_valid, bus_reset, alarm;
   logic        rd_valid, rd_bit;
   swrc_func_t  func;
   logic [7:0]  scratch_crc;
   logic [63:0] code;
   logic [63:0] rx_code          = 64'h0;
   logic [11:0] seen;
   logic [11:0] notes[$];
   logic [7:0]  tv[4] = '{8'h1e, 8'h0a, 8'hec, 8'h00};
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          seed       = 32'h88162cea;

   always #25 clock = ~clock;

   swrc_top #(.SERIAL(SER)) i_dut (
      .clock(clock), .srst(srst), .dq_in(line), .dq_out(dq_out),
      .dq_oe(dq_oe), .scratch(scratch), .conv_done(conv_done),
      .temp_reading(temp_reading), .upper_trip_value(upper_trip_value),
      .lower_trip_value(lower_trip_value), .func(func),
      .func_valid(func_valid), .bus_reset(bus_reset), .alarm(alarm),
      .scratch_crc(scratch_crc));

   swrc_master_model i_master (
      .clock(clock), .dev_oe(dq_oe), .dev_out(dq_out), .line(line),
      .rd_valid(rd_valid), .rd_bit(rd_bit));

   // ==================================================================
   // Reference and reporting
   // Bitwise generator kept apart from the design's own helper
   function automatic logic [7:0] ref_crc(input logic [63:0] d,
                                          input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < n; i++) begin
         c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
      end
      return c;
   endfunction

   task automatic check(input string name, input logic [11:0] s,
                        input logic [11:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, e, s);
      end
   endtask

   task automatic stop_test();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Every bus result takes the oldest note; the top bits give its kind
   always @(posedge clock) begin
      if (rd_valid) begin
         rx_code = {rd_bit, rx_code[63:1]}; // Last 64 sampled bits
      end
      if (rd_valid || func_valid || bus_reset) begin
         seen = rd_valid ? {2'd1, 9'h0, rd_bit}
              : func_valid ? {2'd2, func} : {2'd3, 10'h0};
         if (notes.size() == 0) begin
            check("unexpected result", seen, 12'h0);
         end else begin
            check("bus result", seen, notes.pop_front());
         end
      end
   end

   // One conversion; the flag must follow the signed trip compare
   task automatic convert(input logic [7:0] t);
      logic hot;
      hot = $signed(t) > $signed(upper_trip_value)
            || $signed(t) < $signed(lower_trip_value);
      temp_reading = {{7{t[7]}}, t, 1'b0};
      conv_done = 1'b1;
      @(posedge clock);
      #1 conv_done = 1'b0;
      @(posedge clock);
      #1 check("alarm", {11'h0, alarm}, {11'h0, hot});
   endtask

   // Reset pulse, then the presence sample reads low
   task automatic init_bus();
      notes.push_back({2'd3, 10'h0});
      notes.push_back({2'd1, 10'h0});
      i_master.bus_init();
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      code[55:0]  = {SER, FAMILY_CODE};
      code[63:56] = ref_crc(code, 56);
      repeat (16) @(posedge clock);
      #1 srst = 1'b0;
      // Random images; the check byte trails the contents by one edge
      for (int k = 0; k < 4; k++) begin
         scratch = {$random(seed), $random(seed)};
         repeat (2) @(posedge clock);
         #1 check("scratch_crc", {4'h0, scratch_crc},
                  {4'h0, ref_crc(scratch, 64)});
      end
      // Above, inside, below a negative floor, inside again
      for (int k = 0; k < 4; k++) begin
         convert(tv[k]);
      end
      // Readout: family byte first, check byte last, all LSB first
      init_bus();
      for (int i = 0; i < 64; i++) begin
         notes.push_back({2'd1, 9'h0, code[i]});
      end
      i_master.write_byte(CMD_READ);
      repeat (64) i_master.read_bit();
      // Master side: received code with its check byte leaves zero
      check("code_residue", {4'h0, ref_crc(rx_code, 64)}, 12'h0);
      check("func_sel", {10'h0, func.sel, func.bcast}, 12'h2);
      // Broadcast then scratchpad read, safe with a single slave
      init_bus();
      notes.push_back({2'd2, 1'b0, 1'b1, 8'hbe});
      i_master.write_byte(CMD_BCAST);
      i_master.write_byte(8'hbe);
      // Selection from the last access is gone after the reset
      init_bus();
      check("func_sel", {10'h0, func.sel, func.bcast}, 12'h0);
      // Flag clear: the alarm search gets no answer
      notes.push_back({2'd1, 10'h1});
      notes.push_back({2'd1, 10'h1});
      i_master.write_byte(CMD_ALARM);
      repeat (2) i_master.read_bit();
      // Flag set: it answers like a device search until it loses
      convert(8'h80);
      init_bus();
      i_master.write_byte(CMD_ALARM);
      for (int i = 0; i < 2; i++) begin
         notes.push_back({2'd1, 9'h0, code[i]});
         notes.push_back({2'd1, 9'h0, !code[i]});
         repeat (2) i_master.read_bit();
         i_master.write_bit(i == 0 ? code[0] : !code[1]);
      end
      notes.push_back({2'd1, 10'h1});
      notes.push_back({2'd1, 10'h1});
      repeat (2) i_master.read_bit();
      // A search is always closed by a fresh initialization
      init_bus();
      check("notes_left", 12'(notes.size()), 12'h0);
      stop_test();
   end

   // Full run needs about 7 ms; a hang is cut off well after that
   initial begin
      #9_000_000;
      n_mismatch++;
      stop_test();
   end

endmodule // swrc_tb_top
